// ### pkg/tcc_pkg.sv
// package for the 16-bit timer capture/compare control block
// assumes a single 100 MHz peripheral clock and a 16-bit cpu register port
package tcc_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [15:0] OFS_MODE   = 16'hff60;
  localparam logic [15:0] OFS_PRESC  = 16'hff61;
  localparam logic [15:0] OFS_CCCTL  = 16'hff62;
  localparam logic [15:0] OFS_OUTCTL = 16'hff63;
  localparam logic [15:0] OFS_CNT    = 16'hff10;
  localparam logic [15:0] OFS_CCA    = 16'hff12;
  localparam logic [15:0] OFS_CCB    = 16'hff14;
  localparam logic [7:0]  RST_REG8   = 8'h00;
  localparam logic [15:0] RST_REG16  = 16'h0000;
  localparam logic [15:0] CNT_ONES   = 16'hffff;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  // ==========================================================================
  // field positions
  localparam int MODE_OVF = 0;
  localparam int MODE_TOG = 1;
  localparam int MODE_LO  = 2;
  localparam int MODE_HI  = 3;
  localparam int CC_A_CAP = 0;
  localparam int CC_A_TRG = 1;
  localparam int CC_B_CAP = 2;
  localparam int OC_OE    = 0;
  localparam int OC_TOGA  = 1;
  localparam int OC_LVR   = 2;
  localparam int OC_LVS   = 3;
  localparam int OC_TOGB  = 4;
  localparam int OC_OSE   = 5;
  localparam int OC_OST   = 6;
  localparam int PR_CLK   = 0;
  localparam int PR_EA    = 4;
  localparam int PR_EB    = 6;
  // ==========================================================================
  // count clock selections and edges
  localparam logic [1:0] CK_DIV1   = 2'h0;
  localparam logic [1:0] CK_DIV4   = 2'h1;
  localparam logic [1:0] CK_DIV256 = 2'h2;
  localparam logic [1:0] CK_PIN    = 2'h3;
  localparam logic [7:0] DIV4_LAST   = 8'h03;
  localparam logic [7:0] DIV256_LAST = 8'hff;
  localparam logic [7:0] DIV4_MID    = 8'h01;
  localparam logic [7:0] DIV256_MID  = 8'h7f;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  typedef enum logic [1:0] {
    TCC_STOP = 2'b00, TCC_FREE = 2'b01, TCC_EDGE_CLR = 2'b10, TCC_MATCH_CLR = 2'b11
  } tcc_mode_t;
  // cpu access bundle
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tcc_bus_t;
  // event pulses
  typedef struct packed {
    logic irq_a;
    logic irq_b;
    logic ovf;
  } tcc_evt_t;
endpackage : tcc_pkg

// ### rtl/tcc_edge.sv
// pin synchroniser and valid-edge detector with three-sample noise filter
// assumes pin is asynchronous to clk_in
`timescale 1ns/10ps
`default_nettype none
module tcc_edge (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // pin and selection
  input  wire logic       pin_in,
  input  wire logic       sample_in,
  input  wire logic [1:0] sel_in,
  // detected edges
  output logic            rise_out,
  output logic            fall_out,
  output logic            valid_out
);
  logic       sync1;
  logic       sync2;
  logic [1:0] hist;
  logic       level;
  logic [1:0] next_hist;
  logic       next_level;
  // ==========================================================================
  // filter
  always_comb begin
    next_hist  = hist;
    next_level = level;
    if (sample_in) begin
      next_hist = {hist[0], sync2};
      if (hist[0] == sync2 && hist[1] == sync2) begin
        next_level = sync2;
      end
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      hist  <= 2'b00;
      level <= 1'b0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      hist  <= next_hist;
      level <= next_level;
    end
  end
  assign rise_out  = next_level & ~level;
  assign fall_out  = ~next_level & level;
  assign valid_out = (sel_in == tcc_pkg::EDGE_FALL) ? fall_out :
                     (sel_in == tcc_pkg::EDGE_RISE) ? rise_out :
                     (sel_in == tcc_pkg::EDGE_BOTH) ? (rise_out | fall_out) : 1'b0;
endmodule : tcc_edge
`default_nettype wire

// ### rtl/tcc_timer.sv
// 16-bit timer with two capture/compare registers and output control
// assumes cpu access is one cycle strobes; pins are asynchronous
`timescale 1ns/10ps
`default_nettype none
module tcc_timer (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  // cpu port
  input  wire tcc_pkg::tcc_bus_t  bus_in,
  output logic [15:0]             rdata_out,
  // timer pins
  input  wire logic               timer_in_a,
  input  wire logic               timer_in_b,
  output logic                    timer_out,
  // interrupts
  output tcc_pkg::tcc_evt_t       evt_out
);
  logic [7:0]  mode_reg, presc_reg, ccctl_reg, outctl_reg;
  logic [15:0] count_value, capcmp_reg_a, capcmp_reg_b;
  logic [7:0]  div_cnt;
  logic        out_ff, ovf_window, pend_a, pend_b, ost_pend;
  logic [15:0] rdata;
  logic [7:0]  next_mode, next_presc, next_ccctl, next_outctl, next_div;
  logic [15:0] next_count, next_cca, next_ccb, next_rdata;
  logic        next_out_ff, next_window, next_pend_a, next_pend_b, next_ost;
  logic        running, tick_fall, tick_rise, samp;
  logic        a_rise, a_fall, a_valid, b_rise, b_fall, b_valid;
  logic        match_a, match_b, cap_a, cap_b, wrap, stamp_a, stamp_b;
  tcc_pkg::tcc_mode_t mode;
  tcc_pkg::tcc_evt_t  next_evt, evt;
  assign mode    = tcc_pkg::tcc_mode_t'(mode_reg[tcc_pkg::MODE_HI:tcc_pkg::MODE_LO]);
  assign running = (mode != tcc_pkg::TCC_STOP);
  // ==========================================================================
  // pins
  assign samp = (presc_reg[1:0] == tcc_pkg::CK_PIN) ? 1'b1 : tick_fall;
  tcc_edge u_edge_a (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (timer_in_a),
    .sample_in  (samp),
    .sel_in     (presc_reg[tcc_pkg::PR_EA +: 2]),
    .rise_out   (a_rise),
    .fall_out   (a_fall),
    .valid_out  (a_valid)
  );
  tcc_edge u_edge_b (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .pin_in     (timer_in_b),
    .sample_in  (samp),
    .sel_in     (presc_reg[tcc_pkg::PR_EB +: 2]),
    .rise_out   (b_rise),
    .fall_out   (b_fall),
    .valid_out  (b_valid)
  );
  // ==========================================================================
  // count clock: fall phase midway, rise phase at period end
  always_comb begin
    next_div  = running ? 8'(div_cnt + 8'h01) : tcc_pkg::RST_REG8;
    tick_rise = 1'b0;
    tick_fall = 1'b0;
    case (presc_reg[1:0])
      tcc_pkg::CK_DIV1: begin
        tick_rise = running;
        tick_fall = running;
        next_div  = tcc_pkg::RST_REG8;
      end
      tcc_pkg::CK_DIV4: begin
        tick_fall = running && (div_cnt == tcc_pkg::DIV4_MID);
        tick_rise = running && (div_cnt == tcc_pkg::DIV4_LAST);
        if (tick_rise) next_div = tcc_pkg::RST_REG8;
      end
      tcc_pkg::CK_DIV256: begin
        tick_fall = running && (div_cnt == tcc_pkg::DIV256_MID);
        tick_rise = running && (div_cnt == tcc_pkg::DIV256_LAST);
      end
      default: begin
        tick_rise = running && a_valid;
        tick_fall = tick_rise;
        next_div  = tcc_pkg::RST_REG8;
      end
    endcase
  end
  // ==========================================================================
  // counter, compare and capture
  assign match_a = running && !ccctl_reg[tcc_pkg::CC_A_CAP] && tick_rise
                   && (count_value == capcmp_reg_a);
  assign match_b = running && !ccctl_reg[tcc_pkg::CC_B_CAP] && tick_rise
                   && (count_value == capcmp_reg_b);
  assign wrap    = tick_rise && (count_value == tcc_pkg::CNT_ONES);
  assign cap_a = running && ccctl_reg[tcc_pkg::CC_A_CAP] &&
                 (ccctl_reg[tcc_pkg::CC_A_TRG] ?
                  ((presc_reg[tcc_pkg::PR_EA +: 2] == tcc_pkg::EDGE_FALL) ? a_rise :
                   (presc_reg[tcc_pkg::PR_EA +: 2] == tcc_pkg::EDGE_RISE) ? a_fall : 1'b0)
                  : b_valid);
  assign cap_b = running && ccctl_reg[tcc_pkg::CC_B_CAP] && a_valid;
  assign stamp_a = cap_a && (presc_reg[1:0] == tcc_pkg::CK_PIN || tick_fall);
  assign stamp_b = cap_b && (presc_reg[1:0] == tcc_pkg::CK_PIN || tick_fall);
  always_comb begin
    next_count  = count_value;
    next_cca    = capcmp_reg_a;
    next_ccb    = capcmp_reg_b;
    next_pend_a = pend_a;
    next_pend_b = pend_b;
    next_window = ovf_window;
    next_evt    = '0;
    if (!running) begin
      next_count  = tcc_pkg::RST_REG16;
      next_pend_a = 1'b0;
      next_pend_b = 1'b0;
      next_window = 1'b0;
    end else begin
      if (tick_rise) begin
        next_count = 16'(count_value + tcc_pkg::CNT_ONE);
        if (mode == tcc_pkg::TCC_MATCH_CLR && count_value == capcmp_reg_a) begin
          next_count = tcc_pkg::RST_REG16;
        end
        if (next_count == tcc_pkg::CNT_ONE) next_window = 1'b0;
      end
      if (mode == tcc_pkg::TCC_EDGE_CLR && a_valid) begin
        next_count = tcc_pkg::RST_REG16;
      end
      if (ost_pend && outctl_reg[tcc_pkg::OC_OSE]) next_count = tcc_pkg::RST_REG16;
      if (wrap && capcmp_reg_a == tcc_pkg::CNT_ONES) begin
        next_window = 1'b1;
        next_evt.ovf = 1'b1;
      end
      // captures land on the fall phase, interrupt on next rise
      if (stamp_a) begin
        next_cca    = count_value;
        next_pend_a = 1'b1;
      end
      if (stamp_b) begin
        next_ccb    = count_value;
        next_pend_b = 1'b1;
      end
      if (tick_rise || presc_reg[1:0] == tcc_pkg::CK_PIN) begin
        next_evt.irq_a = match_a | pend_a;
        next_evt.irq_b = match_b | pend_b;
        if (pend_a) next_pend_a = stamp_a;
        if (pend_b) next_pend_b = stamp_b;
      end
    end
    if (bus_in.wr && bus_in.addr == tcc_pkg::OFS_CCA && !ccctl_reg[tcc_pkg::CC_A_CAP]) begin
      next_cca = bus_in.wdata;
    end
    if (bus_in.wr && bus_in.addr == tcc_pkg::OFS_CCB && !ccctl_reg[tcc_pkg::CC_B_CAP]) begin
      next_ccb = bus_in.wdata;
    end
  end
  // ==========================================================================
  // control registers and output flip-flop
  always_comb begin
    next_mode   = mode_reg;
    next_presc  = presc_reg;
    next_ccctl  = ccctl_reg;
    next_outctl = outctl_reg;
    next_out_ff = out_ff;
    next_ost    = 1'b0;
    if (bus_in.wr) begin
      case (bus_in.addr)
        tcc_pkg::OFS_MODE:   next_mode  = {4'h0, bus_in.wdata[3:0]};
        tcc_pkg::OFS_PRESC:  next_presc = {bus_in.wdata[7:4], 2'b00, bus_in.wdata[1:0]};
        tcc_pkg::OFS_CCCTL:  next_ccctl = {5'h00, bus_in.wdata[2:0]};
        tcc_pkg::OFS_OUTCTL: begin
          next_outctl = {3'h0, bus_in.wdata[4], 2'b00, bus_in.wdata[1:0]} |
                        {2'b00, bus_in.wdata[tcc_pkg::OC_OSE], 5'h00};
          next_ost    = bus_in.wdata[tcc_pkg::OC_OST];
          case (bus_in.wdata[tcc_pkg::OC_LVS:tcc_pkg::OC_LVR])
            2'b01:   next_out_ff = 1'b0;
            2'b10:   next_out_ff = 1'b1;
            default: next_out_ff = out_ff;
          endcase
        end
        default: next_mode = mode_reg;
      endcase
    end
    // overflow flag: hardware set wins, window re-sets until count one
    if (next_evt.ovf || (ovf_window && next_window)) next_mode[tcc_pkg::MODE_OVF] = 1'b1;
    if (running) begin
      if ((match_a && outctl_reg[tcc_pkg::OC_TOGA]) ||
          (match_b && outctl_reg[tcc_pkg::OC_TOGB]) ||
          (a_valid && mode_reg[tcc_pkg::MODE_TOG] && mode != tcc_pkg::TCC_EDGE_CLR)) begin
        next_out_ff = ~next_out_ff;
      end
      if (ost_pend && outctl_reg[tcc_pkg::OC_OSE] && mode != tcc_pkg::TCC_MATCH_CLR) begin
        next_out_ff = 1'b1;
      end
    end
  end
  // ==========================================================================
  // read path
  always_comb begin
    case (bus_in.addr)
      tcc_pkg::OFS_MODE:   next_rdata = {8'h00, mode_reg};
      tcc_pkg::OFS_PRESC:  next_rdata = {8'h00, presc_reg};
      tcc_pkg::OFS_CCCTL:  next_rdata = {8'h00, ccctl_reg};
      tcc_pkg::OFS_OUTCTL: next_rdata = {8'h00, outctl_reg};
      tcc_pkg::OFS_CNT:    next_rdata = count_value;
      tcc_pkg::OFS_CCA:    next_rdata = capcmp_reg_a;
      tcc_pkg::OFS_CCB:    next_rdata = capcmp_reg_b;
      default:             next_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_reg     <= tcc_pkg::RST_REG8;
      presc_reg    <= tcc_pkg::RST_REG8;
      ccctl_reg    <= tcc_pkg::RST_REG8;
      outctl_reg   <= tcc_pkg::RST_REG8;
      count_value  <= tcc_pkg::RST_REG16;
      capcmp_reg_a <= tcc_pkg::RST_REG16;
      capcmp_reg_b <= tcc_pkg::RST_REG16;
      div_cnt      <= tcc_pkg::RST_REG8;
      out_ff       <= 1'b0;
      ovf_window   <= 1'b0;
      pend_a       <= 1'b0;
      pend_b       <= 1'b0;
      ost_pend     <= 1'b0;
      rdata        <= tcc_pkg::RST_REG16;
      evt          <= '0;
    end else begin
      mode_reg     <= next_mode;
      presc_reg    <= next_presc;
      ccctl_reg    <= next_ccctl;
      outctl_reg   <= next_outctl;
      count_value  <= next_count;
      capcmp_reg_a <= next_cca;
      capcmp_reg_b <= next_ccb;
      div_cnt      <= next_div;
      out_ff       <= next_out_ff;
      ovf_window   <= next_window;
      pend_a       <= next_pend_a;
      pend_b       <= next_pend_b;
      ost_pend     <= next_ost;
      rdata        <= next_rdata;
      evt          <= next_evt;
    end
  end
  assign rdata_out = rdata;
  assign evt_out   = evt;
  assign timer_out = outctl_reg[tcc_pkg::OC_OE] & out_ff;
  // ==========================================================================
  // checks
  a_stop_clears: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !running |=> count_value == 16'h0000) else $error("counter not held at zero");
  a_stop_no_irq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !running |=> !evt.irq_a && !evt.irq_b) else $error("interrupt while stopped");
  a_out_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !outctl_reg[0] |-> !timer_out) else $error("output not low");
  a_level_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    outctl_reg[3:2] == 2'b00 && !outctl_reg[6]) else $error("write-only bits read one");
  a_ovf_set: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    running && wrap && capcmp_reg_a == 16'hffff |=> ##1 mode_reg[0])
    else $error("overflow flag not set");
  a_match_irq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    match_b |=> evt.irq_b) else $error("compare b match lost");
  a_free_count: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mode == tcc_pkg::TCC_FREE && tick_rise && !ost_pend && !bus_in.wr
    |=> count_value == $past(count_value) + 16'h0001) else $error("count step wrong");
  a_toggle_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    match_a && outctl_reg[1] && !outctl_reg[5] && !bus_in.wr && !match_b && !a_valid
    |=> out_ff != $past(out_ff)) else $error("output not toggled");
endmodule : tcc_timer
`default_nettype wire

// ### sim/tcc_pins_model.sv
// pin-side model: drives both timer inputs, watches the timer output
// assumes pulses are requested by one bench process at a time
`timescale 1ns/10ps
`default_nettype none
module tcc_pins_model (
  // clock
  input  wire logic clk_in,
  // pins
  input  wire logic out_pin_in,
  output logic      pin_a_out,
  output logic      pin_b_out,
  // observation
  output int        rise_cnt_out
);
  logic last_out;
  initial begin
    pin_a_out    = 1'b0;
    pin_b_out    = 1'b0;
    rise_cnt_out = 0;
    last_out     = 1'b0;
  end
  // =========================================================================
  // counts rising edges seen on the output pin
  always @(posedge clk_in) begin
    if (out_pin_in === 1'b1 && last_out !== 1'b1) rise_cnt_out <= rise_cnt_out + 1;
    last_out <= out_pin_in;
  end
  // =========================================================================
  // one full pulse, each level held 8 periph_clk cycles
  task automatic pulse(input bit sel_b);
    @(posedge clk_in);
    #1;
    if (sel_b) pin_b_out = 1'b1;
    else pin_a_out = 1'b1;
    repeat (8) @(posedge clk_in);
    #1;
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
    repeat (8) @(posedge clk_in);
  endtask : pulse
endmodule : tcc_pins_model
`default_nettype wire

// ### sim/timer16_capture_compare_control_test.sv
// self-checking bench for the timer capture/compare control block
// assumes the pin model answers every pulse request in full
`timescale 1ns/10ps
`default_nettype none
module timer16_capture_compare_control_test;
  logic              clk_in;
  logic              reset_n_in;
  tcc_pkg::tcc_bus_t bus;
  tcc_pkg::tcc_evt_t evt;
  logic [15:0]       rdata;
  logic [15:0]       v;
  logic              tout, pa, pb;
  int                rises, r0, na, nb, nov, cyc, error_cnt, total_checks;
  tcc_timer tcc_timer_i (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .bus_in     (bus),
    .rdata_out  (rdata),
    .timer_in_a (pa),
    .timer_in_b (pb),
    .timer_out  (tout),
    .evt_out    (evt)
  );
  tcc_pins_model tcc_pins_model_i (
    .clk_in       (clk_in),
    .out_pin_in   (tout),
    .pin_a_out    (pa),
    .pin_b_out    (pb),
    .rise_cnt_out (rises)
  );
  // =========================================================================
  // clock, event counters, timeout
  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (evt.irq_a === 1'b1) na++;
    if (evt.irq_b === 1'b1) nb++;
    if (evt.ovf === 1'b1) nov++;
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // =========================================================================
  // bus cycles and compares
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    bus = {1'b1, 1'b0, a, d};
    @(posedge clk_in);
    #1;
    bus = {1'b0, 1'b0, a, d};
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_in);
    #1;
    bus = {1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_in);
    #1;
    d = rdata;
    bus = {1'b0, 1'b0, a, 16'h0000};
  endtask : rd
  task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val
  task automatic chk_rng(input string n, input int lo, input int hi, input logic [15:0] g);
    total_checks++;
    if (!((g >= lo && g <= hi) === 1'b1)) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", n, lo, hi, g);
    end
  endtask : chk_rng
  task automatic rc(input logic [15:0] a, input logic [15:0] e, input string n);
    rd(a, v);
    chk_val(n, e, v);
  endtask : rc
  task automatic clr();
    @(posedge clk_in);
    #1;
    na = 0;
    nb = 0;
    nov = 0;
    r0 = rises;
  endtask : clr
  task automatic cfg(input logic [7:0] pr, cc, oc, md, input logic [15:0] ca, cb);
    wr(tcc_pkg::OFS_MODE, 16'h0000);
    wr(tcc_pkg::OFS_PRESC, {8'h00, pr});
    wr(tcc_pkg::OFS_CCCTL, {8'h00, cc});
    wr(tcc_pkg::OFS_CCA, ca);
    wr(tcc_pkg::OFS_CCB, cb);
    wr(tcc_pkg::OFS_OUTCTL, {8'h00, oc});
    wr(tcc_pkg::OFS_MODE, {8'h00, md});
    clr();
  endtask : cfg
  // =========================================================================
  // scenarios
  task automatic t_reset();
    rc(tcc_pkg::OFS_MODE, 16'h0000, "mode reset");
    rc(tcc_pkg::OFS_PRESC, 16'h0000, "presc reset");
    rc(tcc_pkg::OFS_CCCTL, 16'h0000, "ccctl reset");
    rc(tcc_pkg::OFS_OUTCTL, 16'h0000, "outctl reset");
    rc(tcc_pkg::OFS_CNT, 16'h0000, "count reset");
    rc(16'hff70, 16'h0000, "unmapped read");
  endtask : t_reset
  task automatic t_match();
    logic [7:0] oc [4] = '{8'h02, 8'h03, 8'h11, 8'h01};
    int lo [4] = '{0, 4, 4, 0};
    int hi [4] = '{0, 6, 6, 0};
    for (int i = 0; i < 4; i++) begin
      cfg(8'h00, 8'h00, oc[i], 8'h0c, 16'h0009, 16'h0004);
      repeat (100) @(posedge clk_in);
      chk_rng("match a irq", 9, 11, na);
      chk_rng("match b irq", 9, 11, nb);
      chk_rng("out rises", lo[i], hi[i], rises - r0);
    end
    rd(tcc_pkg::OFS_CNT, v);
    chk_rng("match clear count", 0, 9, v);
    cfg(8'h10, 8'h00, 8'h01, 8'h06, 16'hffff, 16'hffff);
    tcc_pins_model_i.pulse(0);
    tcc_pins_model_i.pulse(0);
    chk_rng("edge toggles", 1, 1, rises - r0);
    cfg(8'h10, 8'h00, 8'h01, 8'h0a, 16'hffff, 16'hffff);
    tcc_pins_model_i.pulse(0);
    tcc_pins_model_i.pulse(0);
    chk_rng("edge clear no toggle", 0, 0, rises - r0);
    rd(tcc_pkg::OFS_CNT, v);
    chk_rng("edge clear count", 0, 20, v);
  endtask : t_match
  task automatic t_levels();
    cfg(8'h00, 8'h00, 8'h09, 8'h00, 16'h0000, 16'h0000);
    repeat (3) @(posedge clk_in);
    chk_val("level set", 16'h0001, {15'h0000, tout});
    rc(tcc_pkg::OFS_OUTCTL, 16'h0001, "level bits read");
    wr(tcc_pkg::OFS_OUTCTL, 16'h0005);
    repeat (3) @(posedge clk_in);
    chk_val("level reset", 16'h0000, {15'h0000, tout});
    wr(tcc_pkg::OFS_OUTCTL, 16'h0008);
    repeat (3) @(posedge clk_in);
    chk_val("disabled low", 16'h0000, {15'h0000, tout});
    wr(tcc_pkg::OFS_OUTCTL, 16'h0060);
    rc(tcc_pkg::OFS_OUTCTL, 16'h0020, "trigger reads zero");
  endtask : t_levels
  task automatic t_oneshot();
    cfg(8'h00, 8'h00, 8'h27, 8'h04, 16'h0020, 16'hffff);
    wr(tcc_pkg::OFS_OUTCTL, 16'h0063);
    repeat (40) @(posedge clk_in);
    chk_rng("one-shot pulses", 1, 1, rises - r0);
    wr(tcc_pkg::OFS_OUTCTL, 16'h0063);
    repeat (40) @(posedge clk_in);
    chk_rng("second one-shot", 2, 2, rises - r0);
    chk_val("one-shot end", 16'h0000, {15'h0000, tout});
    cfg(8'h00, 8'h00, 8'h25, 8'h0c, 16'h0020, 16'hffff);
    wr(tcc_pkg::OFS_OUTCTL, 16'h0061);
    repeat (10) @(posedge clk_in);
    chk_rng("no one-shot in match clear", 0, 0, rises - r0);
  endtask : t_oneshot
  task automatic t_overflow();
    cfg(8'h00, 8'h00, 8'h00, 8'h04, 16'hffff, 16'h0000);
    repeat (100) @(posedge clk_in);
    clr();
    for (int i = 0; i < 70000 && nov == 0; i++) @(posedge clk_in);
    repeat (10) @(posedge clk_in);
    chk_rng("ovf pulses", 1, 1, nov);
    chk_rng("zero compare irq", 1, 1, nb);
    chk_rng("all ones irq", 1, 1, na);
    rc(tcc_pkg::OFS_MODE, 16'h0005, "ovf flag");
    wr(tcc_pkg::OFS_MODE, 16'h0004);
    rc(tcc_pkg::OFS_MODE, 16'h0004, "ovf cleared late");
  endtask : t_overflow
  task automatic t_capture();
    logic [1:0] ec [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int ex [4] = '{1, 1, 2, 0};
    for (int i = 0; i < 4; i++) begin
      cfg({ec[i], ec[i], 4'h0}, 8'h05, 8'h00, 8'h04, 16'h0000, 16'h0000);
      tcc_pins_model_i.pulse(0);
      tcc_pins_model_i.pulse(1);
      chk_rng("capture b irq", ex[i], ex[i], nb);
      chk_rng("capture a irq", ex[i], ex[i], na);
    end
    rd(tcc_pkg::OFS_CCB, v);
    chk_rng("captured value", 1, 65535, v);
    wr(tcc_pkg::OFS_CCB, 16'h1234);
    rc(tcc_pkg::OFS_CCB, v, "capture reg write");
    cfg(8'h10, 8'h03, 8'h00, 8'h04, 16'h0000, 16'h0000);
    tcc_pins_model_i.pulse(0);
    chk_rng("reverse phase", 1, 1, na);
    cfg(8'h30, 8'h03, 8'h00, 8'h04, 16'h0000, 16'h0000);
    tcc_pins_model_i.pulse(0);
    chk_rng("reverse both none", 0, 0, na);
  endtask : t_capture
  task automatic t_clock();
    int wt [3] = '{40, 40, 600};
    int lo [3] = '{39, 9, 2};
    int hi [3] = '{44, 11, 3};
    for (int i = 0; i < 3; i++) begin
      cfg(i[7:0], 8'h00, 8'h00, 8'h04, 16'hffff, 16'hffff);
      repeat (wt[i]) @(posedge clk_in);
      rd(tcc_pkg::OFS_CNT, v);
      chk_rng("prescaled count", lo[i], hi[i], v);
    end
    cfg(8'h13, 8'h00, 8'h00, 8'h04, 16'hffff, 16'hffff);
    repeat (5) tcc_pins_model_i.pulse(0);
    rc(tcc_pkg::OFS_CNT, 16'h0005, "pin clock count");
    wr(tcc_pkg::OFS_MODE, 16'h0000);
    rc(tcc_pkg::OFS_CNT, 16'h0000, "stopped count");
    clr();
    tcc_pins_model_i.pulse(0);
    chk_rng("stopped events", 0, 0, na + nb + nov);
  endtask : t_clock
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // =========================================================================
  // main sequence
  initial begin
    bus = '0;
    reset_n_in = 1'b0;
    {na, nb, nov, cyc, error_cnt, total_checks, r0} = '0;
    repeat (5) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    t_reset();
    t_match();
    t_levels();
    t_oneshot();
    t_capture();
    t_clock();
    t_overflow();
    tally_and_finish();
  end
endmodule : timer16_capture_compare_control_test
`default_nettype wire
